// ### logic/rta_trim_alarm.sv
// Overview of operation
// - trim register: sign on top, seven binary-weighted capacitor magnitude bits below.
// - sign 0 adds load capacitance, sign 1 removes it.
// - zero magnitude gives default per-side loading regardless of sign.
// - invalid trim values fall back to default loading, like zero magnitude.
// - shared pin toggles at 512 Hz when test and level bits set, stop clear.
// - test rate uses the undigitally-corrected divider tick only.
// - two alarm groups of five consecutive bytes each.
// - each alarm matches a full date/time or repeats at a chosen period.
// - five repeat bits per alarm, spread over its group, select compared fields.
// - repeat codes: 11111 second, 11110 minute, 11100 hour, 11000 day, 10000 month, 00000 year.
// - undefined repeat codes act as once per second.
// - a match under the chosen criteria sets that alarm's flag.
// - with first-alarm interrupt enabled and the test square wave off, an alarm match drives the pin low.
// - pointer on flags register holds off flag and interrupt until it moves.
// - reading flags releases the interrupt and clears the alarm flags.
// - the clearing read still returns flags set; the next read shows zero.
// - matching and interrupt keep working on backup supply.
// - second alarm works only when enabled; otherwise its bytes are plain storage.
`timescale 1ns/1ps
`default_nettype none
`include "rta_cfg.svh"

module rta_trim_alarm
  import rta_pkg::*;
#(
  parameter int TICK_HZ = `RTA_TICK_HZ,
  parameter int FT_HZ = `RTA_FT_HZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port from the serial engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [4:0] addr_ptr,
  // running time
  input wire logic sec_tick,
  input wire logic [7:0] cur_month,
  input wire logic [7:0] cur_date,
  input wire logic [7:0] cur_hour,
  input wire logic [7:0] cur_minute,
  input wire logic [7:0] cur_second,
  // divider tick and control bits from the clock core
  input wire logic freq_tick,
  input wire logic freq_test_enable,
  input wire logic output_level,
  input wire logic oscillator_stop_bit,
  // capacitor array selects
  output logic trim_sign,
  output logic [6:0] trim_magnitude,
  output logic [6:0] cap_add_sel,
  output logic [6:0] cap_remove_sel,
  // alarm status
  output logic first_alarm_flag,
  output logic second_alarm_flag,
  output logic first_alarm_irq_enable,
  output logic second_alarm_enable,
  // shared open-drain pin
  output logic shared_interrupt_pin_out,
  output logic shared_interrupt_pin_oe
);

  localparam int GROUPS = `RTA_ALARM_COUNT;
  localparam int GBYTES = `RTA_GROUP_BYTES;
  localparam int FT_HALF = (TICK_HZ / (2 * FT_HZ) < 1) ? 1 : TICK_HZ / (2 * FT_HZ);
  localparam int FT_W = (FT_HALF < 2) ? 1 : $clog2(FT_HALF);
  localparam logic [FT_W-1:0] FT_LAST = FT_W'(FT_HALF - 1);

  logic [7:0] alarm_bytes [0:GROUPS*GBYTES-1];
  logic [7:0] trim_reg;
  logic [7:0] ctrl_reg;
  logic [GROUPS-1:0] flags;
  logic [GROUPS-1:0] pending;
  logic [GROUPS-1:0] match;
  logic [GROUPS-1:0] group_en;
  logic [FT_W-1:0] ft_cnt;
  logic ft_phase;
  logic ptr_on_flags;
  logic rd_flags;
  logic in_group1;
  logic in_group2;
  logic [3:0] byte_idx;
  logic [6:0] next_add;
  logic [6:0] next_remove;
  logic trim_valid;
  logic irq_active;
  logic ft_mode;
  rta_pin_mode_t pin_mode;
  logic [7:0] next_rdata;
  logic wr_store;
  logic wr_trim;
  logic wr_ctrl;

  // address decode of the alarm groups
  assign in_group1 = (reg_addr >= `RTA_ADDR_ALARM1_FIRST) && (reg_addr <= `RTA_ADDR_ALARM1_LAST);
  assign in_group2 = (reg_addr >= `RTA_ADDR_ALARM2_FIRST) && (reg_addr <= `RTA_ADDR_ALARM2_LAST);

  // write decode: flags and unmapped addresses take no writes
  assign wr_store = reg_wr && (in_group1 || in_group2);
  assign wr_trim = reg_wr && reg_addr == `RTA_ADDR_TRIM;
  assign wr_ctrl = reg_wr && reg_addr == `RTA_ADDR_CTRL;

  always_comb begin
    byte_idx = 4'h0;
    if (in_group1) begin
      byte_idx = 4'(reg_addr - `RTA_ADDR_ALARM1_FIRST);
    end else if (in_group2) begin
      byte_idx = 4'(reg_addr - `RTA_ADDR_ALARM2_FIRST + 5'(GBYTES));
    end
  end

  // alarm bytes double as plain storage whatever the enable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < GROUPS * GBYTES; i++) begin
        alarm_bytes[i] <= `RTA_BYTE_RESET;
      end
    end else if (wr_store) begin
      alarm_bytes[byte_idx] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trim_reg <= `RTA_TRIM_RESET;
    end else if (wr_trim) begin
      trim_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg <= `RTA_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= reg_wdata;
    end
  end

  // trim decode: limits keep each side inside the array's range
  always_comb begin
    trim_valid = trim_reg[`RTA_BIT_TRIM_SIGN] ? (trim_reg[6:0] <= `RTA_TRIM_MAX_REMOVE)
                                              : (trim_reg[6:0] <= `RTA_TRIM_MAX_ADD);
    next_add = 7'h00;
    next_remove = 7'h00;
    if (trim_valid) begin
      if (trim_reg[`RTA_BIT_TRIM_SIGN]) begin
        next_remove = trim_reg[6:0];
      end else begin
        next_add = trim_reg[6:0];
      end
    end
    // zero magnitude or invalid: both selects stay clear, array at default
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cap_add_sel <= 7'h00;
      cap_remove_sel <= 7'h00;
    end else begin
      cap_add_sel <= next_add;
      cap_remove_sel <= next_remove;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trim_sign <= 1'b0;
      trim_magnitude <= 7'h00;
    end else begin
      trim_sign <= trim_reg[`RTA_BIT_TRIM_SIGN];
      trim_magnitude <= trim_reg[6:0];
    end
  end

  // one comparator per alarm group
  assign group_en[0] = 1'b1;
  assign group_en[1] = ctrl_reg[`RTA_BIT_SECOND_ALARM_ENABLE];

  generate
    for (genvar g = 0; g < GROUPS; g++) begin : g_alarm
      logic [4:0] rpt;
      assign rpt = {alarm_bytes[g*GBYTES+`RTA_BYTE_MONTH][`RTA_BIT_RPT5],
                    alarm_bytes[g*GBYTES+`RTA_BYTE_DATE][`RTA_BIT_RPT_LOW],
                    alarm_bytes[g*GBYTES+`RTA_BYTE_HOUR][`RTA_BIT_RPT_LOW],
                    alarm_bytes[g*GBYTES+`RTA_BYTE_MINUTE][`RTA_BIT_RPT_LOW],
                    alarm_bytes[g*GBYTES+`RTA_BYTE_SECOND][`RTA_BIT_RPT_LOW]};
      // a zeroed date with yearly code never matches, so the alarm is off
      rta_alarm_match u_match (
        .clk(clk),
        .nrst(nrst),
        .sec_tick(sec_tick),
        .enable(group_en[g]),
        .repeat_bits(rpt),
        .set_month(alarm_bytes[g*GBYTES+`RTA_BYTE_MONTH]),
        .set_date(alarm_bytes[g*GBYTES+`RTA_BYTE_DATE]),
        .set_hour(alarm_bytes[g*GBYTES+`RTA_BYTE_HOUR]),
        .set_minute(alarm_bytes[g*GBYTES+`RTA_BYTE_MINUTE]),
        .set_second(alarm_bytes[g*GBYTES+`RTA_BYTE_SECOND]),
        .cur_month(cur_month),
        .cur_date(cur_date),
        .cur_hour(cur_hour),
        .cur_minute(cur_minute),
        .cur_second(cur_second),
        .match(match[g])
      );
    end
  endgenerate

  assign ptr_on_flags = addr_ptr == `RTA_ADDR_FLAGS;
  assign rd_flags = reg_rd && reg_addr == `RTA_ADDR_FLAGS;

  // matches seen while the pointer parks on flags wait here
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pending <= '0;
    end else begin
      for (int i = 0; i < GROUPS; i++) begin
        if (match[i] && ptr_on_flags) begin
          pending[i] <= 1'b1;
        end else if (!ptr_on_flags) begin
          pending[i] <= 1'b0;
        end
      end
    end
  end

  // a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flags <= '0;
    end else begin
      for (int i = 0; i < GROUPS; i++) begin
        if ((match[i] || pending[i]) && !ptr_on_flags) begin
          flags[i] <= 1'b1;
        end else if (rd_flags) begin
          flags[i] <= 1'b0;
        end
      end
    end
  end

  // read data: flags sampled before the clear takes effect
  always_comb begin
    next_rdata = 8'h00;
    if (in_group1 || in_group2) begin
      next_rdata = alarm_bytes[byte_idx];
    end else if (reg_addr == `RTA_ADDR_FLAGS) begin
      next_rdata[`RTA_BIT_AF1] = flags[0];
      next_rdata[`RTA_BIT_AF2] = flags[1];
    end else if (reg_addr == `RTA_ADDR_TRIM) begin
      next_rdata = trim_reg;
    end else if (reg_addr == `RTA_ADDR_CTRL) begin
      next_rdata = ctrl_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      first_alarm_flag <= 1'b0;
      second_alarm_flag <= 1'b0;
    end else begin
      first_alarm_flag <= flags[0];
      second_alarm_flag <= flags[1];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      first_alarm_irq_enable <= 1'b0;
      second_alarm_enable <= 1'b0;
    end else begin
      first_alarm_irq_enable <= alarm_bytes[`RTA_BYTE_MONTH][`RTA_BIT_IRQ_EN];
      second_alarm_enable <= ctrl_reg[`RTA_BIT_SECOND_ALARM_ENABLE];
    end
  end

  // test square wave from the uncorrected divider tick
  assign ft_mode = freq_test_enable & output_level & ~oscillator_stop_bit;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ft_cnt <= '0;
    end else if (!ft_mode) begin
      ft_cnt <= '0;
    end else if (freq_tick) begin
      if (ft_cnt == FT_LAST) begin
        ft_cnt <= '0;
      end else begin
        ft_cnt <= ft_cnt + 1'b1;
      end
    end
  end

  // half period reached on this tick: flip the test output
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ft_phase <= 1'b0;
    end else if (!ft_mode) begin
      ft_phase <= 1'b0;
    end else if (freq_tick && ft_cnt == FT_LAST) begin
      ft_phase <= ~ft_phase;
    end
  end

  assign irq_active = alarm_bytes[`RTA_BYTE_MONTH][`RTA_BIT_IRQ_EN] & (|flags);

  always_comb begin
    if (ft_mode) begin
      pin_mode = RTA_PIN_FREQ_TEST;
    end else if (irq_active) begin
      pin_mode = RTA_PIN_IRQ;
    end else begin
      pin_mode = RTA_PIN_LEVEL;
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shared_interrupt_pin_out <= 1'b0;
    end else begin
      shared_interrupt_pin_out <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      shared_interrupt_pin_oe <= 1'b0;
    end else begin
      case (pin_mode)
        RTA_PIN_FREQ_TEST: shared_interrupt_pin_oe <= ~ft_phase;
        RTA_PIN_IRQ: shared_interrupt_pin_oe <= 1'b1;
        RTA_PIN_LEVEL: shared_interrupt_pin_oe <= ~output_level;
        default: shared_interrupt_pin_oe <= 1'b0;
      endcase
    end
  end

endmodule : rta_trim_alarm
`default_nettype wire

// ### pkg/rta_cfg.svh
`ifndef RTA_CFG_SVH
`define RTA_CFG_SVH

// register map
`define RTA_ADDR_ALARM1_FIRST 5'h0A
`define RTA_ADDR_ALARM1_LAST 5'h0E
`define RTA_ADDR_FLAGS 5'h0F
`define RTA_ADDR_TRIM 5'h12
`define RTA_ADDR_CTRL 5'h13
`define RTA_ADDR_ALARM2_FIRST 5'h14
`define RTA_ADDR_ALARM2_LAST 5'h18

// alarm group layout: byte index within a group
`define RTA_BYTE_MONTH 0
`define RTA_BYTE_DATE 1
`define RTA_BYTE_HOUR 2
`define RTA_BYTE_MINUTE 3
`define RTA_BYTE_SECOND 4
`define RTA_GROUP_BYTES 5
`define RTA_ALARM_COUNT 2

// field positions
`define RTA_BIT_IRQ_EN 7
`define RTA_BIT_RPT5 6
`define RTA_BIT_RPT_LOW 7
`define RTA_BIT_AF1 6
`define RTA_BIT_AF2 5
`define RTA_BIT_SECOND_ALARM_ENABLE 1
`define RTA_BIT_TRIM_SIGN 7
`define RTA_MONTH_MASK 8'h3F
`define RTA_FIELD_MASK 8'h7F

// repeat codes, most significant bit first
`define RTA_RPT_SECOND 5'h1F
`define RTA_RPT_MINUTE 5'h1E
`define RTA_RPT_HOUR 5'h1C
`define RTA_RPT_DAY 5'h18
`define RTA_RPT_MONTH 5'h10
`define RTA_RPT_YEAR 5'h00

// trim magnitude limits in quarter-picofarad steps
`define RTA_TRIM_MAX_ADD 7'h27
`define RTA_TRIM_MAX_REMOVE 7'h48
`define RTA_TRIM_RESET 8'h00
`define RTA_CTRL_RESET 8'h00
`define RTA_BYTE_RESET 8'h00

// frequency test rate and divider tick rate
`define RTA_FT_HZ 512
`define RTA_TICK_HZ 1024

`endif

// ### pkg/rta_pkg.sv
`default_nettype none
package rta_pkg;

  typedef enum logic [2:0] {
    RTA_EVERY_SECOND,
    RTA_EVERY_MINUTE,
    RTA_EVERY_HOUR,
    RTA_EVERY_DAY,
    RTA_EVERY_MONTH,
    RTA_EVERY_YEAR
  } rta_repeat_t;

  typedef enum logic [1:0] {
    RTA_PIN_FREQ_TEST,
    RTA_PIN_IRQ,
    RTA_PIN_LEVEL
  } rta_pin_mode_t;

endpackage : rta_pkg
`default_nettype wire

// ### logic/rta_alarm_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "rta_cfg.svh"

module rta_alarm_match
  import rta_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic sec_tick,
  input wire logic enable,
  input wire logic [4:0] repeat_bits,
  // alarm settings
  input wire logic [7:0] set_month,
  input wire logic [7:0] set_date,
  input wire logic [7:0] set_hour,
  input wire logic [7:0] set_minute,
  input wire logic [7:0] set_second,
  // running time
  input wire logic [7:0] cur_month,
  input wire logic [7:0] cur_date,
  input wire logic [7:0] cur_hour,
  input wire logic [7:0] cur_minute,
  input wire logic [7:0] cur_second,
  // one-cycle match pulse
  output logic match
);

  rta_repeat_t mode;
  logic eq_sec, eq_min, eq_hour, eq_date, eq_month;
  logic hit;

  always_comb begin
    case (repeat_bits)
      `RTA_RPT_MINUTE: mode = RTA_EVERY_MINUTE;
      `RTA_RPT_HOUR: mode = RTA_EVERY_HOUR;
      `RTA_RPT_DAY: mode = RTA_EVERY_DAY;
      `RTA_RPT_MONTH: mode = RTA_EVERY_MONTH;
      `RTA_RPT_YEAR: mode = RTA_EVERY_YEAR;
      default: mode = RTA_EVERY_SECOND;
    endcase
  end

  // repeat bits sit in the top bits and take no part in the compare
  assign eq_sec = (set_second & `RTA_FIELD_MASK) == (cur_second & `RTA_FIELD_MASK);
  assign eq_min = (set_minute & `RTA_FIELD_MASK) == (cur_minute & `RTA_FIELD_MASK);
  assign eq_hour = (set_hour & `RTA_FIELD_MASK) == (cur_hour & `RTA_FIELD_MASK);
  assign eq_date = (set_date & `RTA_FIELD_MASK) == (cur_date & `RTA_FIELD_MASK);
  assign eq_month = (set_month & `RTA_MONTH_MASK) == (cur_month & `RTA_MONTH_MASK);

  always_comb begin
    case (mode)
      RTA_EVERY_SECOND: hit = 1'b1;
      RTA_EVERY_MINUTE: hit = eq_sec;
      RTA_EVERY_HOUR: hit = eq_sec & eq_min;
      RTA_EVERY_DAY: hit = eq_sec & eq_min & eq_hour;
      RTA_EVERY_MONTH: hit = eq_sec & eq_min & eq_hour & eq_date;
      RTA_EVERY_YEAR: hit = eq_sec & eq_min & eq_hour & eq_date & eq_month;
      default: hit = 1'b1;
    endcase
  end

  // one compare per seconds update
  always_ff @(posedge clk) begin
    if (!nrst) begin
      match <= 1'b0;
    end else begin
      match <= sec_tick & enable & hit;
    end
  end

endmodule : rta_alarm_match
`default_nettype wire

// ### tb/rta_trim_alarm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "rta_cfg.svh"
module rta_chk
  import rta_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // inputs
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [4:0] addr_ptr,
  input wire logic sec_tick,
  input wire logic freq_tick,
  input wire logic freq_test_enable,
  input wire logic output_level,
  input wire logic oscillator_stop_bit,
  // outputs
  input wire logic [7:0] reg_rdata,
  input wire logic trim_sign,
  input wire logic [6:0] trim_magnitude,
  input wire logic [6:0] cap_add_sel,
  input wire logic [6:0] cap_remove_sel,
  input wire logic first_alarm_flag,
  input wire logic second_alarm_flag,
  input wire logic first_alarm_irq_enable,
  input wire logic shared_interrupt_pin_oe
);
  logic ft;
  logic ft_q;
  logic on_flags;
  assign ft = freq_test_enable && output_level && !oscillator_stop_bit;
  assign on_flags = addr_ptr == `RTA_ADDR_FLAGS;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ft_q <= 1'b0;
    end else begin
      ft_q <= ft;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_flag_read;
    reg_rd && reg_addr == `RTA_ADDR_FLAGS;
  endsequence
  sequence s_ft_quiet;
    (ft && !freq_tick) [*4];
  endsequence
  sequence s_ft_tick;
    ft ##1 (ft && freq_tick) ##1 ft ##1 ft;
  endsequence
  property p_trim_add;
    $stable({trim_sign, trim_magnitude}) |-> cap_add_sel ==
      ((!trim_sign && trim_magnitude <= `RTA_TRIM_MAX_ADD) ? trim_magnitude : 7'h00);
  endproperty
  property p_trim_remove;
    $stable({trim_sign, trim_magnitude}) |-> cap_remove_sel ==
      ((trim_sign && trim_magnitude <= `RTA_TRIM_MAX_REMOVE) ? trim_magnitude : 7'h00);
  endproperty
  property p_rdata;
    s_flag_read |=> reg_rdata == {1'b0, first_alarm_flag, second_alarm_flag, 5'h00};
  endproperty
  property p_clear;
    s_flag_read ##0 (!$past(sec_tick) && $stable(addr_ptr)) |->
      ##2 (!first_alarm_flag && !second_alarm_flag);
  endproperty
  property p_rise;
    $rose(first_alarm_flag) |-> $past(sec_tick, 3) || $past(on_flags, 3);
  endproperty
  property p_hold;
    on_flags |-> ##2 !$rose(first_alarm_flag) && !$rose(second_alarm_flag);
  endproperty
  property p_irq;
    first_alarm_flag && first_alarm_irq_enable && !ft && !ft_q |-> shared_interrupt_pin_oe;
  endproperty
  property p_level;
    !ft && !ft_q && !first_alarm_flag && !second_alarm_flag && $past(nrst) |->
      shared_interrupt_pin_oe == !$past(output_level);
  endproperty
  property p_ft_hold;
    s_ft_quiet |-> $stable(shared_interrupt_pin_oe);
  endproperty
  property p_ft_toggle;
    s_ft_tick |-> $changed(shared_interrupt_pin_oe);
  endproperty
  a_trim_add: assert property (p_trim_add)
    else $error("add select wrong");
  a_trim_remove: assert property (p_trim_remove)
    else $error("remove select wrong");
  a_rdata: assert property (p_rdata)
    else $error("flags read data wrong");
  a_clear: assert property (p_clear)
    else $error("flags not cleared");
  a_rise: assert property (p_rise)
    else $error("flag set without cause");
  a_hold: assert property (p_hold)
    else $error("flag set with pointer on flags");
  a_irq: assert property (p_irq)
    else $error("pin not pulled low");
  a_level: assert property (p_level)
    else $error("pin not released");
  a_ft_hold: assert property (p_ft_hold)
    else $error("test output moved without tick");
  a_ft_toggle: assert property (p_ft_toggle)
    else $error("test output did not toggle");
endmodule : rta_chk
bind rta_trim_alarm rta_chk chk_u (.clk(clk), .nrst(nrst), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .addr_ptr(addr_ptr), .sec_tick(sec_tick), .freq_tick(freq_tick),
  .freq_test_enable(freq_test_enable), .output_level(output_level),
  .oscillator_stop_bit(oscillator_stop_bit), .reg_rdata(reg_rdata), .trim_sign(trim_sign),
  .trim_magnitude(trim_magnitude), .cap_add_sel(cap_add_sel),
  .cap_remove_sel(cap_remove_sel), .first_alarm_flag(first_alarm_flag),
  .second_alarm_flag(second_alarm_flag), .first_alarm_irq_enable(first_alarm_irq_enable),
  .shared_interrupt_pin_oe(shared_interrupt_pin_oe));
`default_nettype wire

// ### tb/rta_host.sv
`timescale 1ns/1ps
`default_nettype none
module rta_host (
  // clock
  input wire logic clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic [4:0] addr_ptr,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    addr_ptr = 5'h10;
  end
  // idle lines show the inverse of the last value
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    addr_ptr <= a + 5'h01;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    addr_ptr <= a + 5'h01;
    #1 d = reg_rdata;
  endtask : rd
  task automatic off(input logic [4:0] base);
    for (int k = 0; k < 5; k++) begin
      wr(base + 5'(k), 8'h00);
    end
  endtask : off
endmodule : rta_host
`default_nettype wire

// ### tb/rta_trim_alarm_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rta_trim_alarm_tb
  import rta_pkg::*;
;
  logic clk, nrst, reg_wr, reg_rd, sec_tick, freq_tick, fte, lvl, stop, ts, af1, af2, ie, en2;
  logic pin_out, pin_oe, po;
  logic [4:0] reg_addr, addr_ptr;
  logic [7:0] reg_wdata, reg_rdata, v, d, rs;
  logic [6:0] tmag, add_sel, rem_sel;
  logic [7:0] tm [5];
  logic [7:0] cur [5];
  int codes [7] = '{'h1F, 'h1E, 'h1C, 'h18, 'h10, 'h00, 'h0B};
  int nf [7] = '{0, 1, 2, 3, 4, 5, 0};
  logic [7:0] tv [7] = '{8'h00, 8'h80, 8'h27, 8'h28, 8'hC8, 8'hC9, 8'h7F};
  int errors, n_compared, cycles, m, tg;
  rta_host host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .addr_ptr(addr_ptr), .reg_rdata(reg_rdata));
  rta_trim_alarm dut_u (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .addr_ptr(addr_ptr),
    .sec_tick(sec_tick), .cur_month(cur[0]), .cur_date(cur[1]), .cur_hour(cur[2]),
    .cur_minute(cur[3]), .cur_second(cur[4]), .freq_tick(freq_tick),
    .freq_test_enable(fte), .output_level(lvl), .oscillator_stop_bit(stop),
    .trim_sign(ts), .trim_magnitude(tmag), .cap_add_sel(add_sel), .cap_remove_sel(rem_sel),
    .first_alarm_flag(af1), .second_alarm_flag(af2), .first_alarm_irq_enable(ie),
    .second_alarm_enable(en2), .shared_interrupt_pin_out(pin_out),
    .shared_interrupt_pin_oe(pin_oe));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [7:0] rnd();
    rs = {rs[6:0], rs[7] ^ rs[5] ^ rs[4] ^ rs[3]};
    return rs;
  endfunction : rnd
  task automatic report_and_stop();
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t bit %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    host_u.rd(a, d);
    cmp_byte(d, exp);
  endtask : rdc
  task automatic put_group(input logic [4:0] base, input logic [4:0] rpt, input logic en);
    for (int k = 0; k < 5; k++) begin
      host_u.wr(base + 5'(k), (k == 0) ? {en, rpt[4], tm[0][5:0]} : {rpt[4 - k], tm[k][6:0]});
    end
  endtask : put_group
  // field f gets altered, 5 leaves the time equal to the alarm
  task automatic tick(input int f);
    @(posedge clk);
    for (int k = 0; k < 5; k++) begin
      cur[k] <= tm[k] ^ ((k == f) ? 8'h01 : 8'h00);
    end
    sec_tick <= 1'b1;
    @(posedge clk);
    sec_tick <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
  endtask : tick
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    nrst = 1'b0;
    sec_tick = 1'b0;
    freq_tick = 1'b0;
    fte = 1'b0;
    lvl = 1'b1;
    stop = 1'b0;
    rs = 8'h56;
    for (int k = 0; k < 5; k++) cur[k] = 8'h11;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rdc(5'h12, 8'h00);
    rdc(5'h13, 8'h00);
    cmp_bit(en2, 1'b0);
    cmp_bit(pin_out, 1'b0);
    rdc(5'h1F, 8'h00);
    host_u.wr(5'h0F, 8'hFF);
    rdc(5'h0F, 8'h00);
    for (int i = 0; i < 12; i++) begin
      v = (i < 7) ? tv[i] : rnd();
      host_u.wr(5'h12, v);
      rdc(5'h12, v);
      m = v[6:0];
      cmp_byte({ts, tmag}, v);
      cmp_byte({1'b0, add_sel}, (!v[7] && m <= 39) ? 8'(m) : 8'h00);
      cmp_byte({1'b0, rem_sel}, (v[7] && m <= 72) ? 8'(m) : 8'h00);
    end
    for (int i = 0; i < 7; i++) begin
      for (int k = 0; k < 5; k++) tm[k] = (rnd() & 8'h1F) | 8'h10;
      put_group(5'h0A, 5'(codes[i]), 1'b1);
      tick(5);
      cmp_bit(af1, 1'b0);
      cmp_bit(pin_oe, 1'b0);
      cmp_bit(ie, 1'b1);
      host_u.rd(5'h13, d);
      repeat (4) @(posedge clk);
      #1 cmp_bit(af1, 1'b1);
      cmp_bit(pin_oe, 1'b1);
      rdc(5'h0F, 8'h40);
      rdc(5'h0F, 8'h00);
      cmp_bit(pin_oe, 1'b0);
      for (int f = 0; f < 5; f++) begin
        tick(f);
        cmp_bit(af1, (f < 5 - nf[i]));
        cmp_bit(pin_oe, (f < 5 - nf[i]));
        rdc(5'h0F, {1'b0, (f < 5 - nf[i]), 6'h00});
        rdc(5'h0F, 8'h00);
      end
    end
    host_u.off(5'h0A);
    put_group(5'h14, 5'h1F, 1'b0);
    rdc(5'h16, {1'b1, tm[2][6:0]});
    tick(5);
    cmp_bit(af2, 1'b0);
    cmp_bit(af1, 1'b0);
    cmp_bit(ie, 1'b0);
    host_u.wr(5'h13, 8'h02);
    rdc(5'h13, 8'h02);
    cmp_bit(en2, 1'b1);
    tick(5);
    cmp_bit(af2, 1'b1);
    cmp_bit(pin_oe, 1'b0);
    rdc(5'h0F, 8'h20);
    @(posedge clk);
    fte <= 1'b1;
    repeat (4) @(posedge clk);
    #1 po = pin_oe;
    tg = 0;
    for (int j = 0; j < 42; j++) begin
      @(posedge clk);
      freq_tick <= (j % 6 == 0);
      #1;
      if (pin_oe !== po) tg++;
      po = pin_oe;
    end
    cmp_byte(8'(tg), 8'h07);
    @(posedge clk);
    stop <= 1'b1;
    repeat (3) @(posedge clk);
    #1 cmp_bit(pin_oe, 1'b0);
    cmp_bit(pin_out, 1'b0);
    report_and_stop();
  end
endmodule : rta_trim_alarm_tb
`default_nettype wire
